// file: ucti_defines.svh
// Register offsets, field positions, reset values and counts of the block
`ifndef UCTI_DEFINES_SVH
`define UCTI_DEFINES_SVH

// Register byte offsets
`define UCTI_CTRL1_OFS     12'h000
`define UCTI_AUX_OFS       12'h004
`define UCTI_FLAG_OFS      12'h008
`define UCTI_STATE_OFS     12'h00c

// Control register one reset value and masks
`define UCTI_CTRL1_RST     32'h0000_0000
`define UCTI_CTRL1_WMASK   32'h1fff_ffff
`define UCTI_CTRL1_LOCKED  32'h13ff_8e00

// Control register one field positions
`define UCTI_B_WLEN_HI     28
`define UCTI_B_EOB_IE      27
`define UCTI_B_RTO_IE      26
`define UCTI_B_DRIVE_ASSERT_DELAY_LSB    21
`define UCTI_B_DRIVE_RELEASE_DELAY_LSB    16
`define UCTI_B_OVERSAMPLE_SELECT       15
`define UCTI_B_CM_IE       14
`define UCTI_B_MUTE        13
`define UCTI_B_WLEN_LO     12
`define UCTI_B_WAKE        11
`define UCTI_B_PAR_ON      10
`define UCTI_B_PAR_ODD     9
`define UCTI_B_PE_IE       8
`define UCTI_B_TXE_IE      7
`define UCTI_B_TC_IE       6
`define UCTI_B_RECEIVE_NOT_EMPTY_FLAG_IE     5
`define UCTI_B_IDLE_IE     4
`define UCTI_B_TX_ON       3
`define UCTI_B_RX_ON       2
`define UCTI_B_STOP_WAKE   1
`define UCTI_B_UNIT_ON     0

// Auxiliary enable register fields
`define UCTI_AUX_RST       3'h0
`define UCTI_B_CTS_IE      0
`define UCTI_B_LBD_IE      1
`define UCTI_B_WUF_IE      2

// Flag register: transmitter acknowledge position
`define UCTI_B_TE_ACK      12

// Sample periods in one bit
`define UCTI_OS16_SAMPLES  5'h10
`define UCTI_OS8_SAMPLES   5'h08

`endif

// file: ucti_pkg.sv
// Types shared by the control and interrupt block
package ucti_pkg;

  // Event flags from the transceiver core
  typedef struct packed {
    logic end_block_flag;
    logic rx_timeout_flag;
    logic wakeup_flag;
    logic char_match_flag;
    logic lbd;
    logic pe;
    logic idle;
    logic overrun_error_flag;
    logic receive_not_empty_flag;
    logic tc;
    logic cts;
    logic transmit_empty_flag;
  } ucti_flags_s;

  // Frame configuration handed to the core
  typedef struct packed {
    logic word_9bit;
    logic oversample_select;
    logic parity_on;
    logic parity_odd_select;
    logic mute_allow;
    logic wake_addr;
  } ucti_cfg_s;

  // Driver enable sequencer states
  typedef enum logic [4:0] {
    DS_IDLE    = 5'b00001,
    DS_GUARD   = 5'b00010,
    DS_ASSERT  = 5'b00100,
    DS_SEND    = 5'b01000,
    DS_RELEASE = 5'b10000
  } ucti_drv_state_e;

endpackage

// file: ucti_delay_cnt.sv
// Sample-period delay counter for driver enable and guard timing
`timescale 1ns/100ps
module ucti_delay_cnt #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  input  wire logic             clr,
  input  wire logic             tick,
  output logic                  done
);
  logic             active_reg;
  logic [WIDTH-1:0] cnt_reg;

  // Refuse widths too narrow for the five-bit delay fields
  if (WIDTH < 5) begin : g_width_check
    $error("ucti_delay_cnt: WIDTH below 5");
  end

  // Load, count down on sample ticks, stop on clear
  always_ff @(posedge clk) begin
    if (srst) begin
      active_reg <= 1'b0;
      cnt_reg    <= '0;
    end else if (ce) begin
      if (clr) begin
        active_reg <= 1'b0;
        cnt_reg    <= '0;
      end else if (load) begin
        active_reg <= 1'b1;
        cnt_reg    <= value;
      end else if (active_reg && tick && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Delay elapsed
  assign done = active_reg && (cnt_reg == '0);
endmodule // ucti_delay_cnt

// file: ucti_top.sv
// Control register, interrupt merge, wake and driver enable timing
`timescale 1ns/100ps
`include "ucti_defines.svh"
module ucti_top (
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire ucti_pkg::ucti_flags_s EVT_FLAGS,
  input  wire logic                 SAMPLE_TICK,
  input  wire logic                 TX_DATA_PENDING,
  input  wire logic                 TX_FRAME_DONE,
  input  wire logic                 CORE_BUSY,
  input  wire logic                 SMARTCARD_MODE,
  input  wire logic                 STOP_MODE,
  input  wire logic                 CLK_SRC_OK,
  input  wire logic                 STANDBY,
  input  wire logic                 PREAMBLE_DONE,
  output ucti_pkg::ucti_cfg_s       FRAME_CFG,
  output logic                      RECEIVER_ON,
  output logic                      UNIT_RESET,
  output logic                      TX_GO,
  output logic                      LINE_DRIVER_ENABLE,
  output logic                      PREAMBLE_REQ,
  output logic                      TRANSMITTER_ON_ACK,
  output logic                      IRQ,
  output logic                      STOP_WAKE
);
  import ucti_pkg::*;

  logic [31:0]     ctrl_reg;
  logic [2:0]      aux_reg;
  logic [31:0]     ctrl_next;
  logic            wr_en;
  logic            setup;
  logic            hit;
  logic [31:0]     rd_next;
  ucti_flags_s     flags_q;
  logic            unit_on;
  logic            te_prev_reg;
  logic            te_rise;
  ucti_drv_state_e state_reg;
  ucti_drv_state_e state_next;
  logic            cnt_load;
  logic [4:0]      cnt_value;
  logic            cnt_done;
  logic            irq_next;
  logic            wake_next;
  logic            pwr_rst;
  logic [4:0]      bit_samples;

  // Standby drops all state like a power-on reset
  assign pwr_rst = SRST | STANDBY;
  assign unit_on = ctrl_reg[`UCTI_B_UNIT_ON];

  // Address decode of the four word registers
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `UCTI_CTRL1_OFS) || (a == `UCTI_AUX_OFS) ||
               (a == `UCTI_FLAG_OFS) || (a == `UCTI_STATE_OFS);
  endfunction

  // Field extract of a five-bit delay
  function automatic logic [4:0] field5(input logic [31:0] r,
                                        input int lsb);
    field5 = r[lsb +: 5];
  endfunction

  assign setup = PSEL && !PENABLE;
  assign hit   = addr_hit(PADDR);
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && hit;

  // Locked fields keep their value while the unit is on
  always_comb begin
    ctrl_next = ctrl_reg;
    if (unit_on) begin
      ctrl_next = (ctrl_reg & `UCTI_CTRL1_LOCKED) |
                  (PWDATA & `UCTI_CTRL1_WMASK & ~`UCTI_CTRL1_LOCKED);
    end else begin
      ctrl_next = PWDATA & `UCTI_CTRL1_WMASK;
    end
  end

  // Control register one
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      ctrl_reg <= `UCTI_CTRL1_RST;
    end else if (CE) begin
      if (wr_en && PADDR == `UCTI_CTRL1_OFS) begin
        ctrl_reg <= ctrl_next;
      end
    end
  end

  // Auxiliary enables for events whose enables live elsewhere
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      aux_reg <= `UCTI_AUX_RST;
    end else if (CE) begin
      if (wr_en && PADDR == `UCTI_AUX_OFS) begin
        aux_reg <= PWDATA[2:0];
      end
    end
  end

  // Flags read as default while the unit is off
  assign flags_q = unit_on ? EVT_FLAGS : '0;

  // Read data mux
  always_comb begin
    rd_next = 32'h0000_0000;
    case (PADDR)
      `UCTI_CTRL1_OFS: rd_next = ctrl_reg;
      `UCTI_AUX_OFS:   rd_next = {29'h0000_0000, aux_reg};
      `UCTI_FLAG_OFS:  rd_next = {19'h0_0000, TRANSMITTER_ON_ACK,
                                  flags_q};
      `UCTI_STATE_OFS: rd_next = {25'h000_0000, PREAMBLE_REQ,
                                  LINE_DRIVER_ENABLE, 5'(state_reg)} ;
      default:         rd_next = 32'h0000_0000;
    endcase
  end

  // Zero-wait APB answer, read data captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CE) begin
      PREADY  <= setup;
      PSLVERR <= setup && !hit;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // Frame settings move to the core only between bytes
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      FRAME_CFG <= '0;
    end else if (CE) begin
      if (!CORE_BUSY) begin
        FRAME_CFG.word_9bit <= ctrl_reg[`UCTI_B_WLEN_LO] &
                               !ctrl_reg[`UCTI_B_WLEN_HI];
        FRAME_CFG.oversample_select <= ctrl_reg[`UCTI_B_OVERSAMPLE_SELECT];
        FRAME_CFG.parity_on <= ctrl_reg[`UCTI_B_PAR_ON];
        FRAME_CFG.parity_odd_select <= ctrl_reg[`UCTI_B_PAR_ODD];
        FRAME_CFG.mute_allow <= ctrl_reg[`UCTI_B_MUTE];
        FRAME_CFG.wake_addr <= ctrl_reg[`UCTI_B_WAKE];
      end
    end
  end

  // Unit and receiver controls to the core
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      RECEIVER_ON        <= 1'b0;
      UNIT_RESET         <= 1'b1;
      TRANSMITTER_ON_ACK <= 1'b0;
      te_prev_reg        <= 1'b0;
    end else if (CE) begin
      RECEIVER_ON        <= unit_on && ctrl_reg[`UCTI_B_RX_ON];
      UNIT_RESET         <= !unit_on;
      TRANSMITTER_ON_ACK <= unit_on && ctrl_reg[`UCTI_B_TX_ON];
      te_prev_reg        <= ctrl_reg[`UCTI_B_TX_ON];
    end
  end

  assign te_rise = ctrl_reg[`UCTI_B_TX_ON] && !te_prev_reg;
  assign bit_samples = ctrl_reg[`UCTI_B_OVERSAMPLE_SELECT] ? `UCTI_OS8_SAMPLES
                                               : `UCTI_OS16_SAMPLES;

  // Driver enable sequencer
  always_comb begin
    state_next = state_reg;
    cnt_load   = 1'b0;
    cnt_value  = field5(ctrl_reg, `UCTI_B_DRIVE_ASSERT_DELAY_LSB);
    case (state_reg)
      DS_IDLE: begin
        if (te_rise && SMARTCARD_MODE) begin
          state_next = DS_GUARD;
          cnt_load   = 1'b1;
          cnt_value  = bit_samples;
        end else if (TX_DATA_PENDING && TRANSMITTER_ON_ACK) begin
          state_next = DS_ASSERT;
          cnt_load   = 1'b1;
        end
      end
      DS_GUARD: begin
        if (cnt_done) begin
          state_next = DS_IDLE;
        end
      end
      DS_ASSERT: begin
        if (cnt_done) begin
          state_next = DS_SEND;
        end
      end
      DS_SEND: begin
        if (TX_FRAME_DONE && !TX_DATA_PENDING) begin
          state_next = DS_RELEASE;
          cnt_load   = 1'b1;
          cnt_value  = field5(ctrl_reg, `UCTI_B_DRIVE_RELEASE_DELAY_LSB);
        end
      end
      DS_RELEASE: begin
        if (cnt_done && TX_DATA_PENDING) begin
          state_next = DS_ASSERT;
          cnt_load   = 1'b1;
        end else if (cnt_done) begin
          state_next = DS_IDLE;
        end
      end
      default: state_next = DS_IDLE;
    endcase
    if (!unit_on || !ctrl_reg[`UCTI_B_TX_ON]) begin
      state_next = DS_IDLE;
      cnt_load   = 1'b0;
    end
  end

  ucti_delay_cnt #(
    .WIDTH (5)
  ) u_delay (
    .clk   (CLK),
    .srst  (pwr_rst),
    .ce    (CE),
    .load  (cnt_load),
    .value (cnt_value),
    .clr   (!unit_on),
    .tick  (SAMPLE_TICK),
    .done  (cnt_done)
  );

  // Sequencer state and line outputs
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      state_reg          <= DS_IDLE;
      TX_GO              <= 1'b0;
      LINE_DRIVER_ENABLE <= 1'b0;
    end else if (CE) begin
      state_reg          <= state_next;
      TX_GO              <= (state_next == DS_SEND);
      LINE_DRIVER_ENABLE <= (state_next == DS_ASSERT) ||
                            (state_next == DS_SEND) ||
                            (state_next == DS_RELEASE);
    end
  end

  // Preamble request: set wins over the core's done
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      PREAMBLE_REQ <= 1'b0;
    end else if (CE) begin
      if (!unit_on) begin
        PREAMBLE_REQ <= 1'b0;
      end else if (te_rise && !SMARTCARD_MODE && CORE_BUSY) begin
        PREAMBLE_REQ <= 1'b1;
      end else if (PREAMBLE_DONE) begin
        PREAMBLE_REQ <= 1'b0;
      end
    end
  end

  // Merge of all enabled events; stop wake comes only from the receive not empty and wakeup events
  always_comb begin
    irq_next = (flags_q.transmit_empty_flag  && ctrl_reg[`UCTI_B_TXE_IE])  ||
               (flags_q.tc   && ctrl_reg[`UCTI_B_TC_IE])   ||
               (flags_q.pe   && ctrl_reg[`UCTI_B_PE_IE])   ||
               (flags_q.idle && ctrl_reg[`UCTI_B_IDLE_IE]) ||
               ((flags_q.receive_not_empty_flag || flags_q.overrun_error_flag) &&
                ctrl_reg[`UCTI_B_RECEIVE_NOT_EMPTY_FLAG_IE])                 ||
               (flags_q.char_match_flag  && ctrl_reg[`UCTI_B_CM_IE])   ||
               (flags_q.rx_timeout_flag && ctrl_reg[`UCTI_B_RTO_IE])  ||
               (flags_q.end_block_flag && ctrl_reg[`UCTI_B_EOB_IE])  ||
               (flags_q.cts  && aux_reg[`UCTI_B_CTS_IE])   ||
               (flags_q.lbd  && aux_reg[`UCTI_B_LBD_IE])   ||
               (flags_q.wakeup_flag  && aux_reg[`UCTI_B_WUF_IE]);
    wake_next = STOP_MODE && CLK_SRC_OK &&
                ctrl_reg[`UCTI_B_STOP_WAKE] &&
                ((flags_q.receive_not_empty_flag && ctrl_reg[`UCTI_B_RECEIVE_NOT_EMPTY_FLAG_IE]) ||
                 (flags_q.wakeup_flag && aux_reg[`UCTI_B_WUF_IE]));
  end

  // Registered interrupt and stop wake outputs
  always_ff @(posedge CLK) begin
    if (pwr_rst) begin
      IRQ       <= 1'b0;
      STOP_WAKE <= 1'b0;
    end else if (CE) begin
      IRQ       <= irq_next;
      STOP_WAKE <= wake_next;
    end
  end

  // Checks
  chk_locked_fields: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && unit_on && wr_en && PADDR == `UCTI_CTRL1_OFS |=>
    (ctrl_reg & `UCTI_CTRL1_LOCKED) == ($past(ctrl_reg) & `UCTI_CTRL1_LOCKED))
    else $error("locked field changed while unit on");

  chk_reserved_zero: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_reg[31:29] == 3'h0)
    else $error("reserved control bits not zero");

  chk_irq_rx_merge: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && unit_on && ctrl_reg[`UCTI_B_RECEIVE_NOT_EMPTY_FLAG_IE] &&
    EVT_FLAGS.overrun_error_flag |=> IRQ)
    else $error("overrun did not raise interrupt");

  chk_irq_masked: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && (ctrl_reg[8:4] == 5'h00) &&
    ctrl_reg[27:26] == 2'h0 && !ctrl_reg[14] && aux_reg == 3'h0 |=> !IRQ)
    else $error("interrupt without an enable");

  chk_eob_irq: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && unit_on && ctrl_reg[`UCTI_B_EOB_IE] &&
    EVT_FLAGS.end_block_flag |=> IRQ)
    else $error("end of block did not raise interrupt");

  chk_stop_wake: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && !CLK_SRC_OK |=> !STOP_WAKE)
    else $error("stop wake with unsuitable clock");

  chk_de_before_go: assert property (@(posedge CLK) disable iff (SRST)
    $rose(TX_GO) |-> LINE_DRIVER_ENABLE && $past(LINE_DRIVER_ENABLE))
    else $error("start allowed without driver enable lead");

  chk_release_hold: assert property (@(posedge CLK) disable iff (SRST)
    state_reg == DS_RELEASE |-> !TX_GO)
    else $error("data sent during release delay");

  chk_unit_off: assert property (@(posedge CLK) disable iff (SRST)
    CE && !unit_on |=> !LINE_DRIVER_ENABLE && !TX_GO && UNIT_RESET)
    else $error("outputs active with unit off");

  chk_rx_on: assert property (@(posedge CLK) disable iff (SRST)
    CE && !STANDBY && !ctrl_reg[`UCTI_B_RX_ON] |=> !RECEIVER_ON)
    else $error("receiver on while disabled");

  chk_cfg_hold: assert property (@(posedge CLK) disable iff (SRST)
    CORE_BUSY && !STANDBY |=> $stable(FRAME_CFG))
    else $error("frame settings changed mid byte");

  chk_guard_wait: assert property (@(posedge CLK) disable iff (SRST)
    state_reg == DS_GUARD |-> ##1 !TX_GO)
    else $error("smartcard start inside guard bit");

endmodule // ucti_top

// file: ucti_core_model.sv
// Behavioural transceiver core that faces the control block
`timescale 1ns/100ps
module ucti_core_model #(
  parameter int TICK_DIV  = 4,
  parameter int FRAME_LEN = 40
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic unit_reset,
  input  wire logic tx_go,
  input  wire logic preamble_req,
  output logic      sample_tick,
  output logic      frame_done,
  output logic      core_busy,
  output logic      preamble_done
);
  int div_cnt;
  int bit_cnt;
  int pre_cnt;

  // Sample period strobe, one pulse every TICK_DIV cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt     <= 0;
      sample_tick <= 1'b0;
    end else begin
      div_cnt     <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      sample_tick <= (div_cnt == TICK_DIV - 1);
    end
  end

  // Frames start only while sending is allowed; unit off drops them
  always_ff @(posedge clk) begin
    if (srst || unit_reset) begin
      core_busy  <= 1'b0;
      frame_done <= 1'b0;
      bit_cnt    <= 0;
    end else begin
      frame_done <= 1'b0;
      if (!core_busy && tx_go && !frame_done) begin
        core_busy <= 1'b1;
        bit_cnt   <= FRAME_LEN;
      end else if (core_busy) begin
        bit_cnt <= bit_cnt - 1;
        if (bit_cnt == 1) begin
          core_busy  <= 1'b0;
          frame_done <= 1'b1;
        end
      end
    end
  end

  // Idle preamble is reported sent a fixed time after it is queued
  always_ff @(posedge clk) begin
    if (srst) begin
      pre_cnt       <= 0;
      preamble_done <= 1'b0;
    end else begin
      preamble_done <= preamble_req && pre_cnt == 7;
      pre_cnt       <= (preamble_req && pre_cnt < 7) ? pre_cnt + 1 : 0;
    end
  end
endmodule // ucti_core_model

// file: ucti_tb.sv
// Self-checking bench for the control, interrupt and driver timing block
`timescale 1ns/100ps
module tb;
  import ucti_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ucti_flags_s flags;
  ucti_cfg_s   cfg;
  logic        tick, pend, fdone, busy, smart, stop, src_ok, stby, pdone;
  logic        rx_on, ures, tx_go, de, pre_req, ack, irq, wake;
  logic        watch, dropped, ce;
  int          error_cnt, cmp_count, t;

  ucti_top i_dut (.CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVT_FLAGS(flags),
    .SAMPLE_TICK(tick), .TX_DATA_PENDING(pend), .TX_FRAME_DONE(fdone),
    .CORE_BUSY(busy), .SMARTCARD_MODE(smart), .STOP_MODE(stop),
    .CLK_SRC_OK(src_ok), .STANDBY(stby), .PREAMBLE_DONE(pdone),
    .FRAME_CFG(cfg), .RECEIVER_ON(rx_on), .UNIT_RESET(ures), .TX_GO(tx_go),
    .LINE_DRIVER_ENABLE(de), .PREAMBLE_REQ(pre_req),
    .TRANSMITTER_ON_ACK(ack), .IRQ(irq), .STOP_WAKE(wake));

  ucti_core_model #(.TICK_DIV(4), .FRAME_LEN(40)) i_core (.clk(clk),
    .srst(srst), .unit_reset(ures), .tx_go(tx_go), .preamble_req(pre_req),
    .sample_tick(tick), .frame_done(fdone), .core_busy(busy),
    .preamble_done(pdone));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Notes any drop of the line driver while watched
  always @(posedge clk) if (watch && de === 1'b0) dropped <= 1'b1;

  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task fail_wait(input string nm);
    error_cnt++;
    $display("wrong value %s expected event seen timeout", nm);
    stop_test();
  endtask

  // One full-word transfer; result left in rd and err
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_wait("pready");
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  function automatic logic sig(int w);
    case (w)
      0: return de;
      1: return tx_go;
      2: return pre_req;
      default: return busy;
    endcase
  endfunction

  task wait_sig(int w, logic v, string nm);
    int n;
    for (n = 0; n < 400 && sig(w) !== v; n++) @(posedge clk);
    if (n == 400) fail_wait(nm);
  endtask

  // Counts sample ticks until the watched output reaches v
  task count_ticks(int w, logic v);
    t = 0;
    for (int n = 0; n < 400 && sig(w) !== v; n++) begin
      t += (tick === 1'b1);
      @(posedge clk);
    end
    if (sig(w) !== v) fail_wait("tick count");
  endtask

  task t_regs;
    apb(0, 12'h000, 0);
    chk("ctrl reset", 32'h0, rd);
    chk("unit reset", 1, ures);
    apb(1, 12'h000, 32'hffff_fffe);
    apb(0, 12'h000, 0);
    chk("reserved bits", 32'h1fff_fffe, rd);
    apb(1, 12'h000, 32'h0000_be00);
    repeat (2) @(posedge clk);
    chk("frame cfg", 32'h3f, cfg);
    apb(1, 12'h000, 32'h1000_0000);
    repeat (2) @(posedge clk);
    chk("reserved length", 32'h0, cfg);
    apb(0, 12'h010, 0);
    chk("unmapped error", 1, err);
    $display("register test done");
  endtask

  task t_lock;
    apb(1, 12'h000, 32'h0062_0000);
    apb(1, 12'h000, 32'h0062_000d);
    apb(1, 12'h000, 32'h13ff_8e0d);
    apb(0, 12'h000, 0);
    chk("locked fields", 32'h0062_000d, rd);
    chk("receiver on", 1, rx_on);
    chk("transmit ack", 1, ack);
    chk("unit running", 0, ures);
    apb(1, 12'h000, 32'h0062_0009);
    repeat (2) @(posedge clk);
    chk("receiver off", 0, rx_on);
    $display("lock test done");
  endtask

  task t_driver;
    pend <= 1'b1;
    wait_sig(0, 1, "driver on");
    count_ticks(1, 1);
    chk("assert ticks", 3, t);
    pend <= 1'b0;
    wait_sig(1, 0, "send end");
    count_ticks(0, 0);
    chk("release ticks", 2, t);
    pend <= 1'b1;
    wait_sig(1, 1, "send again");
    pend <= 1'b0;
    wait_sig(1, 0, "send end");
    {dropped, watch, pend} <= 3'b011;
    count_ticks(1, 1);
    chk("held data ticks", 1, t >= 5);
    chk("driver held", 0, dropped);
    {watch, pend} <= 2'b00;
    wait_sig(0, 0, "driver off");
    $display("driver test done");
  endtask

  task t_preamble;
    pend <= 1'b1;
    wait_sig(1, 1, "send");
    pend <= 1'b0;
    wait_sig(3, 1, "core busy");
    apb(1, 12'h000, 32'h0062_0001);
    apb(1, 12'h000, 32'h0062_0009);
    repeat (2) @(posedge clk);
    chk("preamble queued", 1, pre_req);
    wait_sig(2, 0, "preamble done");
    $display("preamble test done");
  endtask

  task t_smart;
    smart <= 1'b1;
    apb(1, 12'h000, 32'h0062_0001);
    apb(1, 12'h000, 32'h0062_0009);
    apb(0, 12'h00c, 0);
    chk("guard state", 32'h2, rd & 32'h1f);
    pend <= 1'b1;
    count_ticks(0, 1);
    chk("guard ticks", 1, t >= 15);
    wait_sig(1, 1, "send");
    {pend, smart} <= 2'b00;
    wait_sig(0, 0, "driver off");
    $display("smartcard test done");
  endtask

  task automatic t_irq;
    int fi[9] = '{11, 10, 8, 6, 0, 2, 5, 3, 4};
    int eb[9] = '{27, 26, 14, 8, 7, 6, 4, 5, 5};
    for (int i = 0; i < 9; i++) begin
      apb(1, 12'h000, 32'h1);
      flags <= ucti_flags_s'(12'h1 << fi[i]);
      repeat (3) @(posedge clk);
      chk("irq masked", 0, irq);
      apb(1, 12'h000, 32'h1 | (32'h1 << eb[i]));
      repeat (3) @(posedge clk);
      chk("irq on", 1, irq);
      flags <= '0;
      repeat (3) @(posedge clk);
      chk("irq gone", 0, irq);
    end
    $display("interrupt test done");
  endtask

  task t_wake;
    flags <= ucti_flags_s'(12'h008);
    {stop, src_ok} <= 2'b11;
    apb(1, 12'h000, 32'h23);
    repeat (3) @(posedge clk);
    chk("wake on receive", 1, wake);
    src_ok <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake wrong clock", 0, wake);
    src_ok <= 1'b1;
    apb(1, 12'h000, 32'h21);
    repeat (3) @(posedge clk);
    chk("wake disabled", 0, wake);
    flags <= ucti_flags_s'(12'h200);
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h000, 32'h3);
    repeat (3) @(posedge clk);
    chk("wake on wakeup", 1, wake);
    chk("irq on wakeup", 1, irq);
    {ce, flags, stop} <= '0;
    repeat (3) @(posedge clk);
    chk("irq frozen", 1, irq);
    chk("wake frozen", 1, wake);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq thawed", 0, irq);
    chk("wake thawed", 0, wake);
    $display("wake test done");
  endtask

  task t_standby;
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h000, 0);
    chk("config kept", 32'h0062_0000, rd);
    chk("unit off", 1, ures);
    flags <= ucti_flags_s'(12'hfff);
    apb(0, 12'h008, 0);
    chk("flags cleared", 32'h0, rd);
    flags <= '0;
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    apb(0, 12'h000, 0);
    chk("standby clears", 32'h0, rd);
    $display("standby test done");
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pend, smart, stop, src_ok, stby, watch, dropped} = '0;
    flags = '0;
    ce = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    srst = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_lock();
    t_driver();
    t_preamble();
    t_smart();
    t_irq();
    t_wake();
    t_standby();
    stop_test();
  end
endmodule // tb
